//--- rtl/wmrf_regfile.sv
// Wide-mode general-purpose register file and segment selector file
//
// Contract
// - Sixteen registers; default operand size 32 bits.
// - Byte, word, dword, qword access on every register.
// - Prefix needed for 64-bit size or added registers.
// - Added registers survive wide-compat-wide round trip.
// - After legacy round trip added registers undefined.
// - With prefix, byte codes 4-7 select low bytes.
// - Never mix legacy high byte with new bytes.
// - 64-bit result writes all 64 bits.
// - 32-bit result zero-extends, clearing upper half.
// - 8/16-bit writes keep upper 56/48 bits.
// - Upper halves undefined after leaving wide mode.
// - Six segment registers holding 16-bit selectors.
// - Fetch address from code selector plus pointer.
// - Code segment rejects explicit loads.
// - Stack operations use stack segment; loadable.
// - Wide mode: code/data/extra/stack base zero.
// - Wide mode: aux segments keep their bases.
// - Wide-mode loads still run legacy selector checks.
// - Wide mode disables segment limit checks.
// - Legacy high bytes are bits 15:8 of regs 0-3.
`timescale 1ns/1ps
`include "wmrf_regs.svh"

module wmrf_regfile
  import wmrf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire wmrf_mode_type mode_req,
  input wire wmrf_operand_type rd_req,
  input wire wmrf_write_type wr_req,
  input wire wmrf_seg_load_type seg_req,
  input wire wmrf_addr_req_type addr_req,
  input wire logic [63:0] instruction_pointer,
  output logic [63:0] rd_data,
  output logic rd_valid,
  output logic seg_fault,
  output logic [63:0] lin_addr,
  output logic addr_valid,
  output logic [15:0] fetch_sel,
  output logic [63:0] fetch_addr,
  output logic limit_check_en,
  output wmrf_mode_type mode,
  output logic added_regs_defined,
  output logic upper_halves_defined
);

  wmrf_state_type s;
  wmrf_state_type next_s;

  // Prefix bits only count when the prefix is present
  function automatic logic [3:0] reg_index(input wmrf_operand_type o);
    reg_index = {o.prefix & o.prefix_r, o.field};
  endfunction

  function automatic wmrf_size_type op_size(input wmrf_operand_type o);
    if (o.byte_op) begin
      op_size = WMRF_SZ8;
    end else if (o.prefix && o.prefix_w) begin
      op_size = WMRF_SZ64;
    end else if (o.word_op) begin
      op_size = WMRF_SZ16;
    end else begin
      op_size = WMRF_SZ32;
    end
  endfunction

  // Legacy high byte: byte code 4-7 with no prefix
  function automatic logic high_byte(input wmrf_operand_type o);
    high_byte = o.byte_op && !o.prefix && o.field[2];
  endfunction

  function automatic logic [3:0] byte_reg(input wmrf_operand_type o);
    if (high_byte(o)) begin
      byte_reg = {2'h0, o.field[1:0]};
    end else begin
      byte_reg = reg_index(o);
    end
  endfunction

  function automatic logic [63:0] eff_base(input wmrf_state_type st,
                                           input logic [2:0] seg);
    if (st.mode == WMRF_WIDE && seg != `WMRF_SEG_AUX_A &&
        seg != `WMRF_SEG_AUX_B) begin
      eff_base = 64'h0000000000000000;
    end else begin
      eff_base = st.base[seg];
    end
  endfunction

  logic [3:0] ridx;
  logic [3:0] widx;
  logic [2:0] aseg;
  logic sel_null;
  logic [63:0] rreg;

  always_comb begin
    next_s = s;
    next_s.rd_valid = 1'b0;
    next_s.seg_fault = 1'b0;
    next_s.addr_valid = 1'b0;
    ridx = byte_reg(rd_req);
    widx = byte_reg(wr_req.op);
    rreg = s.gpr[ridx];
    aseg = addr_req.stack_op ? `WMRF_SEG_STACK : addr_req.seg;
    sel_null = seg_req.selector[`WMRF_SEL_NULL_MSB:`WMRF_SEL_NULL_LSB]
               == 14'h0000;

    // Contents are kept on every transition; the flags only say what
    // software may still rely on
    case (mode_req)
      WMRF_WIDE: begin
        next_s.mode = WMRF_WIDE;
      end
      WMRF_COMPAT: begin
        next_s.mode = WMRF_COMPAT;
        next_s.upper_defined = 1'b0;
      end
      WMRF_LEGACY: begin
        next_s.mode = WMRF_LEGACY;
        next_s.upper_defined = 1'b0;
        next_s.added_defined = 1'b0;
      end
      default: begin
        next_s.mode = s.mode;
      end
    endcase
    next_s.limit_check_en = next_s.mode != WMRF_WIDE;

    // Read reflects the file before this cycle's write
    if (rd_req.valid) begin
      next_s.rd_valid = 1'b1;
      case (op_size(rd_req))
        WMRF_SZ8: begin
          next_s.rd_data = high_byte(rd_req) ? {56'h0, rreg[15:8]}
                                             : {56'h0, rreg[7:0]};
        end
        WMRF_SZ16: begin
          next_s.rd_data = {48'h0, rreg[15:0]};
        end
        WMRF_SZ32: begin
          next_s.rd_data = {32'h0, rreg[31:0]};
        end
        default: begin
          next_s.rd_data = rreg;
        end
      endcase
    end

    if (wr_req.op.valid) begin
      case (op_size(wr_req.op))
        WMRF_SZ8: begin
          if (high_byte(wr_req.op)) begin
            next_s.gpr[widx][15:8] = wr_req.data[7:0];
          end else begin
            next_s.gpr[widx][7:0] = wr_req.data[7:0];
          end
        end
        WMRF_SZ16: begin
          next_s.gpr[widx][15:0] = wr_req.data[15:0];
        end
        WMRF_SZ32: begin
          next_s.gpr[widx] = {32'h0, wr_req.data[31:0]};
        end
        default: begin
          next_s.gpr[widx] = wr_req.data;
        end
      endcase
    end

    // Legacy checks run in every mode so compat code can reuse the value
    if (seg_req.valid) begin
      if (seg_req.seg > `WMRF_SEG_AUX_B) begin
        next_s.seg_fault = 1'b1;
      end else if (seg_req.seg == `WMRF_SEG_CODE &&
                   !seg_req.implicit_load) begin
        next_s.seg_fault = 1'b1;
      end else if ((seg_req.seg == `WMRF_SEG_CODE ||
                    seg_req.seg == `WMRF_SEG_STACK) && sel_null) begin
        next_s.seg_fault = 1'b1;
      end else begin
        next_s.sel[seg_req.seg] = seg_req.selector;
        next_s.base[seg_req.seg] = seg_req.base;
      end
    end

    if (addr_req.valid) begin
      next_s.addr_valid = 1'b1;
      if (aseg > `WMRF_SEG_AUX_B) begin
        next_s.lin_addr = addr_req.offset;
      end else begin
        next_s.lin_addr = eff_base(s, aseg) + addr_req.offset;
      end
    end

    next_s.fetch_sel = s.sel[`WMRF_SEG_CODE];
    next_s.fetch_addr = eff_base(s, `WMRF_SEG_CODE) + instruction_pointer;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < `WMRF_GPR_COUNT; i++) begin
        s.gpr[i] <= `WMRF_GPR_RESET;
      end
      for (int j = 0; j < `WMRF_SEG_COUNT; j++) begin
        s.sel[j] <= `WMRF_SEL_RESET;
        s.base[j] <= `WMRF_BASE_RESET;
      end
      s.mode <= WMRF_LEGACY;
      // Reset zeroes every register, so all contents count as defined
      s.added_defined <= 1'b1;
      s.upper_defined <= 1'b1;
      s.rd_data <= 64'h0000000000000000;
      s.rd_valid <= 1'b0;
      s.seg_fault <= 1'b0;
      s.lin_addr <= 64'h0000000000000000;
      s.addr_valid <= 1'b0;
      s.fetch_sel <= `WMRF_SEL_RESET;
      s.fetch_addr <= 64'h0000000000000000;
      s.limit_check_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.rd_data;
  assign rd_valid = s.rd_valid;
  assign seg_fault = s.seg_fault;
  assign lin_addr = s.lin_addr;
  assign addr_valid = s.addr_valid;
  assign fetch_sel = s.fetch_sel;
  assign fetch_addr = s.fetch_addr;
  assign limit_check_en = s.limit_check_en;
  assign mode = s.mode;
  assign added_regs_defined = s.added_defined;
  assign upper_halves_defined = s.upper_defined;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic wr8;
  logic wr32;
  logic wr64;
  logic wr16;
  assign wr8 = wr_req.op.valid && op_size(wr_req.op) == WMRF_SZ8 &&
               !high_byte(wr_req.op);
  assign wr16 = wr_req.op.valid && op_size(wr_req.op) == WMRF_SZ16;
  assign wr32 = wr_req.op.valid && op_size(wr_req.op) == WMRF_SZ32;
  assign wr64 = wr_req.op.valid && op_size(wr_req.op) == WMRF_SZ64;

  zero_ext_write_a: assert property (
    wr32 |=> s.gpr[$past(widx)] == {32'h0, $past(wr_req.data[31:0])})
    else $error("32-bit write did not zero-extend");

  quad_write_a: assert property (
    wr64 |=> s.gpr[$past(widx)] == $past(wr_req.data))
    else $error("64-bit write did not update all bits");

  byte_keep_a: assert property (
    wr8 && !rd_req.valid |=>
      s.gpr[$past(widx)][63:8] == $past(s.gpr[widx][63:8]))
    else $error("byte write disturbed upper bits");

  prefix_byte_a: assert property (
    rd_req.valid && rd_req.byte_op && rd_req.prefix &&
    !rd_req.prefix_r && rd_req.field == 3'h4 |=>
      rd_data == {56'h0, $past(s.gpr[`WMRF_IDX_SP][7:0])})
    else $error("prefixed byte code 4 did not select low byte");

  high_byte_a: assert property (
    rd_req.valid && rd_req.byte_op && !rd_req.prefix &&
    rd_req.field == 3'h4 |=> rd_data == {56'h0, $past(s.gpr[0][15:8])})
    else $error("legacy high byte read wrong bits");

  default_size_a: assert property (
    rd_req.valid && !rd_req.byte_op && !rd_req.word_op &&
    !rd_req.prefix |=> rd_valid && rd_data[63:32] == 32'h0)
    else $error("default read was not 32 bits");

  code_reject_a: assert property (
    seg_req.valid && seg_req.seg == `WMRF_SEG_CODE &&
    !seg_req.implicit_load |=> seg_fault && $stable(s.sel[0]))
    else $error("explicit code segment load accepted");

  stack_load_a: assert property (
    seg_req.valid && seg_req.seg == `WMRF_SEG_STACK && !sel_null |=>
      !seg_fault && s.sel[2] == $past(seg_req.selector))
    else $error("stack segment load not taken");

  flat_base_a: assert property (
    s.mode == WMRF_WIDE && addr_req.valid && !addr_req.stack_op &&
    addr_req.seg == `WMRF_SEG_DATA |=> lin_addr == $past(addr_req.offset))
    else $error("data segment base not zero in wide mode");

  aux_base_a: assert property (
    s.mode == WMRF_WIDE && addr_req.valid && !addr_req.stack_op &&
    addr_req.seg == `WMRF_SEG_AUX_B |=>
      lin_addr == $past(s.base[5]) + $past(addr_req.offset))
    else $error("aux segment base not added");

  limit_off_a: assert property (
    mode_req == WMRF_WIDE |=> !limit_check_en ##1
      (limit_check_en == (s.mode != WMRF_WIDE)))
    else $error("limit checks not off in wide mode");

  added_keep_a: assert property (
    s.mode == WMRF_COMPAT && !wr_req.op.valid |=> $stable(s.gpr[8]))
    else $error("added register changed without a write");

  fetch_sel_a: assert property (
    ##1 fetch_sel == $past(s.sel[0]))
    else $error("fetch selector not from code segment");

  fetch_load_a: assert property (
    seg_req.valid && seg_req.seg == `WMRF_SEG_CODE &&
    seg_req.implicit_load && !sel_null |=>
      ##1 fetch_sel == $past(seg_req.selector, 2))
    else $error("loaded code selector not used for fetch");

  word_keep_a: assert property (
    wr16 |=>
      s.gpr[$past(widx)][63:16] == $past(s.gpr[widx][63:16]))
    else $error("word write disturbed upper bits");

  seg_null_a: assert property (
    seg_req.valid && seg_req.seg == `WMRF_SEG_STACK && sel_null |=>
      seg_fault && $stable(s.sel[2]))
    else $error("null stack selector accepted");

  compat_flag_a: assert property (
    mode_req == WMRF_COMPAT |=> !upper_halves_defined)
    else $error("upper halves still marked defined");

  legacy_flag_a: assert property (
    mode_req == WMRF_LEGACY |=> !added_regs_defined)
    else $error("added registers still marked defined");

  read_pulse_a: assert property (
    1'b1 |=> rd_valid == $past(rd_req.valid))
    else $error("read answer pulse wrong");

  fetch_addr_a: assert property (
    s.mode == WMRF_WIDE |=> fetch_addr == $past(instruction_pointer))
    else $error("code base not zero in wide mode");

  wide_quad_c: cover property (s.mode == WMRF_WIDE && wr64);
  legacy_trip_c: cover property (
    s.mode == WMRF_LEGACY ##1 s.mode == WMRF_COMPAT ##2 s.mode == WMRF_WIDE);
  code_reject_c: cover property (seg_fault && s.mode == WMRF_WIDE);
  aux_base_c: cover property (addr_valid && s.mode == WMRF_WIDE);

endmodule

//--- rtl/wmrf_regs.svh
// Constants for the wide-mode register and segment file
`ifndef WMRF_REGS_SVH
`define WMRF_REGS_SVH

`define WMRF_GPR_COUNT 16
`define WMRF_SEG_COUNT 6
`define WMRF_IDX_SP 4'h4
`define WMRF_SEG_CODE 3'h0
`define WMRF_SEG_DATA 3'h1
`define WMRF_SEG_STACK 3'h2
`define WMRF_SEG_EXTRA 3'h3
`define WMRF_SEG_AUX_A 3'h4
`define WMRF_SEG_AUX_B 3'h5
`define WMRF_SEL_NULL_MSB 15
`define WMRF_SEL_NULL_LSB 2
`define WMRF_GPR_RESET 64'h0000000000000000
`define WMRF_SEL_RESET 16'h0000
`define WMRF_BASE_RESET 64'h0000000000000000

`endif

//--- rtl/wmrf_pkg.sv
// Types for the wide-mode register and segment file
package wmrf_pkg;

  typedef enum logic [2:0] {
    WMRF_WIDE = 3'h1,
    WMRF_COMPAT = 3'h2,
    WMRF_LEGACY = 3'h4
  } wmrf_mode_type;

  typedef enum logic [1:0] {
    WMRF_SZ8 = 2'h0,
    WMRF_SZ16 = 2'h1,
    WMRF_SZ32 = 2'h2,
    WMRF_SZ64 = 2'h3
  } wmrf_size_type;

  // Operand selection as decode hands it over
  typedef struct packed {
    logic valid;
    logic prefix;
    logic prefix_w;
    logic prefix_r;
    logic byte_op;
    logic word_op;
    logic [2:0] field;
  } wmrf_operand_type;

  typedef struct packed {
    wmrf_operand_type op;
    logic [63:0] data;
  } wmrf_write_type;

  typedef struct packed {
    logic valid;
    logic implicit_load;
    logic [2:0] seg;
    logic [15:0] selector;
    logic [63:0] base;
  } wmrf_seg_load_type;

  typedef struct packed {
    logic valid;
    logic stack_op;
    logic [2:0] seg;
    logic [63:0] offset;
  } wmrf_addr_req_type;

  typedef struct packed {
    logic [15:0][63:0] gpr;
    logic [5:0][15:0] sel;
    logic [5:0][63:0] base;
    wmrf_mode_type mode;
    logic added_defined;
    logic upper_defined;
    logic [63:0] rd_data;
    logic rd_valid;
    logic seg_fault;
    logic [63:0] lin_addr;
    logic addr_valid;
    logic [15:0] fetch_sel;
    logic [63:0] fetch_addr;
    logic limit_check_en;
  } wmrf_state_type;

endpackage

//--- verif/wmrf_pipe_model.sv
// Decode and execute pipeline model that issues register file requests
`timescale 1ns/1ps
module wmrf_pipe_model
  import wmrf_pkg::*;
(
  input wire logic mclk,
  output wmrf_mode_type mode_req,
  output wmrf_operand_type rd_req,
  output wmrf_write_type wr_req,
  output wmrf_seg_load_type seg_req,
  output wmrf_addr_req_type addr_req,
  output logic [63:0] instruction_pointer,
  input wire logic [63:0] rd_data,
  input wire logic rd_valid,
  input wire logic seg_fault,
  input wire logic [63:0] lin_addr,
  input wire logic addr_valid
);
  initial begin
    // Start wide so the status flags keep their reset value
    mode_req = WMRF_WIDE;
    rd_req = '0;
    wr_req = '0;
    seg_req = '0;
    addr_req = '0;
    instruction_pointer = 64'h4000;
  end
  // Dropped requests show inverted fields so stale values never pass
  task automatic rd(input wmrf_operand_type o, output logic [64:0] q);
    @(negedge mclk);
    rd_req <= o;
    @(negedge mclk);
    rd_req <= ~o;
    q = {rd_valid, rd_data};
  endtask
  task automatic wr(input wmrf_operand_type o, input logic [63:0] d);
    @(negedge mclk);
    wr_req <= {o, d};
    @(negedge mclk);
    wr_req <= ~{o, d};
  endtask
  task automatic sg(input wmrf_seg_load_type s, output logic f);
    @(negedge mclk);
    seg_req <= s;
    @(negedge mclk);
    seg_req <= ~s;
    f = seg_fault;
  endtask
  task automatic ad(input wmrf_addr_req_type a, output logic [64:0] q);
    @(negedge mclk);
    addr_req <= a;
    @(negedge mclk);
    addr_req <= ~a;
    q = {addr_valid, lin_addr};
  endtask
  // Callers read back contents after a compat drop, upper half included, but never after a legacy drop
  task automatic go(input wmrf_mode_type m);
    @(negedge mclk);
    mode_req <= m;
    @(negedge mclk);
  endtask
endmodule

//--- verif/wmrf_regfile_tb_top.sv
// Self-checking testbench for the wide-mode register and segment file
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED at %0t: value differs", $time); end end
module wmrf_regfile_tb_top
  import wmrf_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  wmrf_mode_type mode_req, mode;
  wmrf_operand_type rd_req;
  wmrf_write_type wr_req;
  wmrf_seg_load_type seg_req;
  wmrf_addr_req_type addr_req;
  logic [63:0] instruction_pointer, rd_data, lin_addr, fetch_addr;
  logic rd_valid, seg_fault, addr_valid, limit_check_en;
  logic [15:0] fetch_sel;
  logic added_regs_defined, upper_halves_defined;
  int n_mismatch = 0;
  int checked = 0;
  logic [64:0] q;
  logic f;

  always #5 mclk = ~mclk;

  wmrf_pipe_model wmrf_pipe_model_inst (.mclk, .mode_req, .rd_req,
    .wr_req, .seg_req, .addr_req, .instruction_pointer, .rd_data,
    .rd_valid, .seg_fault, .lin_addr, .addr_valid);
  wmrf_regfile wmrf_regfile_inst (.mclk, .rst, .mode_req, .rd_req,
    .wr_req, .seg_req, .addr_req, .instruction_pointer, .rd_data,
    .rd_valid, .seg_fault, .lin_addr, .addr_valid, .fetch_sel,
    .fetch_addr, .limit_check_en, .mode, .added_regs_defined,
    .upper_halves_defined);

  // Flags are prefix, prefix_w, prefix_r, byte_op, word_op
  function automatic wmrf_operand_type opd(input logic [4:0] fl,
                                           input logic [2:0] fd);
    return {1'b1, fl, fd};
  endfunction
  function automatic wmrf_seg_load_type sl(input logic imp,
    input logic [2:0] s, input logic [15:0] sel, input logic [63:0] b);
    return {1'b1, imp, s, sel, b};
  endfunction

  task automatic wrap_up;
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic t_sizes;
    wmrf_pipe_model_inst.rd(opd(5'h1C, 3'h1), q);
    `CHK(q, {1'b1, 64'h0})
    wmrf_pipe_model_inst.go(WMRF_WIDE);
    `CHK(limit_check_en, 1'b0)
    wmrf_pipe_model_inst.wr(opd(5'h1C, 3'h1), 64'h1122334455667788);
    wmrf_pipe_model_inst.rd(opd(5'h1C, 3'h1), q);
    `CHK(q, {1'b1, 64'h1122334455667788})
    wmrf_pipe_model_inst.rd(opd(5'h18, 3'h1), q);
    `CHK(q, {1'b1, 64'h0})
    wmrf_pipe_model_inst.wr(opd(5'h15, 3'h1), 64'hFFFFFFFFFFFFAAAA);
    wmrf_pipe_model_inst.wr(opd(5'h16, 3'h1), 64'hFFFFFFFFFFFFFFBB);
    wmrf_pipe_model_inst.rd(opd(5'h1C, 3'h1), q);
    `CHK(q, {1'b1, 64'h112233445566AABB})
    wmrf_pipe_model_inst.rd(opd(5'h15, 3'h1), q);
    `CHK(q, {1'b1, 64'hAABB})
    wmrf_pipe_model_inst.wr(opd(5'h14, 3'h1), 64'hFFFFFFFFCAFE0001);
    wmrf_pipe_model_inst.rd(opd(5'h1C, 3'h1), q);
    `CHK(q, {1'b1, 64'hCAFE0001})
  endtask

  task automatic t_bytes;
    wmrf_pipe_model_inst.wr(opd(5'h18, 3'h0), 64'h0706050403020100);
    wmrf_pipe_model_inst.wr(opd(5'h18, 3'h4), 64'hAAAAAAAAAAAAAA44);
    wmrf_pipe_model_inst.rd(opd(5'h02, 3'h4), q);
    `CHK(q, {1'b1, 64'h01})
    wmrf_pipe_model_inst.rd(opd(5'h12, 3'h4), q);
    `CHK(q, {1'b1, 64'h44})
    wmrf_pipe_model_inst.wr(opd(5'h02, 3'h4), 64'h5A);
    wmrf_pipe_model_inst.rd(opd(5'h18, 3'h0), q);
    `CHK(q, {1'b1, 64'h0706050403025A00})
    wmrf_pipe_model_inst.rd(opd(5'h00, 3'h0), q);
    `CHK(q, {1'b1, 64'h03025A00})
  endtask

  task automatic t_modes;
    `CHK(upper_halves_defined, 1'b1)
    wmrf_pipe_model_inst.wr(opd(5'h1C, 3'h5), 64'h0123456789ABCDEF);
    wmrf_pipe_model_inst.go(WMRF_COMPAT);
    `CHK(limit_check_en, 1'b1)
    `CHK(upper_halves_defined, 1'b0)
    `CHK(added_regs_defined, 1'b1)
    wmrf_pipe_model_inst.go(WMRF_WIDE);
    `CHK(mode, WMRF_WIDE)
    wmrf_pipe_model_inst.rd(opd(5'h1C, 3'h5), q);
    `CHK(q, {1'b1, 64'h0123456789ABCDEF})
    wmrf_pipe_model_inst.go(WMRF_LEGACY);
    `CHK(added_regs_defined, 1'b0)
    `CHK(limit_check_en, 1'b1)
    wmrf_pipe_model_inst.go(WMRF_COMPAT);
    wmrf_pipe_model_inst.go(WMRF_WIDE);
    `CHK(mode, WMRF_WIDE)
  endtask

  task automatic t_segs;
    wmrf_pipe_model_inst.sg(sl(1'b0, 3'h0, 16'h0008, 64'h1000), f);
    `CHK(f, 1'b1)
    wmrf_pipe_model_inst.sg(sl(1'b1, 3'h0, 16'h0010, 64'h1000), f);
    `CHK(f, 1'b0)
    @(negedge mclk);
    `CHK(fetch_sel, 16'h0010)
    `CHK(fetch_addr, 64'h4000)
    wmrf_pipe_model_inst.sg(sl(1'b0, 3'h2, 16'h0003, 64'h2000), f);
    `CHK(f, 1'b1)
    wmrf_pipe_model_inst.sg(sl(1'b0, 3'h2, 16'h0018, 64'h2000), f);
    `CHK(f, 1'b0)
    wmrf_pipe_model_inst.ad({1'b1, 1'b1, 3'h5, 64'h40}, q);
    `CHK(q, {1'b1, 64'h40})
    wmrf_pipe_model_inst.sg(sl(1'b0, 3'h4, 16'h0020, 64'h8000), f);
    wmrf_pipe_model_inst.ad({1'b1, 1'b0, 3'h4, 64'h10}, q);
    `CHK(q, {1'b1, 64'h8010})
    wmrf_pipe_model_inst.sg(sl(1'b0, 3'h1, 16'h0028, 64'h9000), f);
    wmrf_pipe_model_inst.ad({1'b1, 1'b0, 3'h1, 64'h10}, q);
    `CHK(q, {1'b1, 64'h10})
    wmrf_pipe_model_inst.sg(sl(1'b0, 3'h5, 16'h0030, 64'hA000), f);
    `CHK(f, 1'b0)
    wmrf_pipe_model_inst.ad({1'b1, 1'b0, 3'h5, 64'h20}, q);
    `CHK(q, {1'b1, 64'hA020})
    wmrf_pipe_model_inst.sg(sl(1'b0, 3'h6, 16'h0038, 64'h0), f);
    `CHK(f, 1'b1)
  endtask

  initial begin
    repeat (8) @(negedge mclk);
    rst <= 1'b0;
    t_sizes();
    t_bytes();
    t_modes();
    t_segs();
    wrap_up();
  end

  // A full pass needs about 85 cycles; this is far beyond that
  initial begin
    repeat (2000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end
endmodule
